/* File: pkg/temp_params.svh */
// Register offsets, field positions, reset values and timing figures of the
// temperature result back end. Included by the package and the design files.
`ifndef TEMP_PARAMS_SVH
`define TEMP_PARAMS_SVH

// Register offsets
`define ADDR_CONFIG_ONE          8'h01
`define ADDR_CONFIG_TWO          8'h02
`define ADDR_LOCAL_HIGH          8'h0b
`define ADDR_LOCAL_LOW           8'h0c
`define ADDR_LOCAL_OVERTEMP      8'h0d
`define ADDR_REMOTE_HIGH         8'h0e
`define ADDR_REMOTE_LOW          8'h0f
`define ADDR_REMOTE_OVERTEMP     8'h10
`define ADDR_LOCAL_CORRECTION    8'h16
`define ADDR_REMOTE_CORRECTION   8'h17
`define ADDR_LOCAL_FRACTION      8'h40
`define ADDR_LOCAL_WHOLE         8'h41
`define ADDR_REMOTE_FRACTION     8'h42
`define ADDR_REMOTE_WHOLE        8'h43

// Field positions
`define CFG1_MONITOR_RUN_BIT     0
`define CFG1_AVG_DISABLE_BIT     1
`define CFG2_CHANNEL_SEL_BIT     4
`define CFG2_ROUND_ROBIN_BIT     7

// Reset values
`define RST_CONFIG_ONE           8'h01
`define RST_CONFIG_TWO           8'h80
`define RST_HIGH_LIMIT           8'h8b
`define RST_LOW_LIMIT            8'h54
`define RST_OVERTEMP_LIMIT       8'h95
`define RST_CORRECTION           8'h00
`define RST_READING              13'h0000

// Result format
`define READING_W                13
`define FRACTION_W               5
`define READING_MAX              13'h1fff
`define AVG_SAMPLES              16
`define AVG_SHIFT                4
`define CORRECTION_SHIFT         2

// Timing
`define CLK_PERIOD_NS            100
`define NS_PER_MS                1000000
`define SLOT_LOCAL_MS            11
`define SLOT_REMOTE_AVG_MS       32
`define SLOT_REMOTE_RAW_MS       6

`endif

/* File: pkg/temp_pkg.sv */
// Types shared by the temperature result back end.
// Assumes temp_params.svh sits on the include path.
`include "temp_params.svh"

package temp_pkg;

  typedef logic [`READING_W-1:0] reading_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] overtemp;
  } limits_t;

  typedef struct packed {
    logic high;
    logic low;
    logic overtemp;
  } limit_flags_t;

  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b001,
    SEQ_START   = 3'b010,
    SEQ_CONVERT = 3'b100
  } seq_state_t;

endpackage

/* File: rtl/reading_averager.sv */
// Averages raw converter samples in groups of sixteen, or passes each through.
// Assumes samples arrive as one-cycle strobes; clear restarts a group.
`timescale 1ns/1ps
`include "temp_params.svh"

module reading_averager #(
  parameter int SAMPLES = `AVG_SAMPLES,
  parameter int SHIFT   = `AVG_SHIFT
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clear,
  input  wire logic              average_en,
  input  wire logic              sample_valid,
  input  wire temp_pkg::reading_t sample,
  output logic                   result_valid,
  output temp_pkg::reading_t     result
);
  import temp_pkg::*;

  localparam int ACC_W = `READING_W + SHIFT;

  logic [ACC_W-1:0] acc;
  logic [SHIFT-1:0] count;
  logic [ACC_W-1:0] next_acc;
  logic [SHIFT-1:0] next_count;
  logic             next_result_valid;
  reading_t         next_result;
  logic [ACC_W-1:0] sum;

  // Accumulate; the group is emitted on its last sample so nothing is lost
  always_comb begin
    sum               = acc + {{SHIFT{1'b0}}, sample};
    next_acc          = acc;
    next_count        = count;
    next_result_valid = 1'b0;
    next_result       = result;
    if (clear) begin
      next_acc   = '0;
      next_count = '0;
    end else if (sample_valid && !average_en) begin
      next_result_valid = 1'b1;
      next_result       = sample;
    end else if (sample_valid) begin
      if (count == SHIFT'(SAMPLES - 1)) begin
        next_result_valid = 1'b1;
        next_result       = sum[ACC_W-1:SHIFT];
        next_acc          = '0;
        next_count        = '0;
      end else begin
        next_acc   = sum;
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc          <= '0;
      count        <= '0;
      result_valid <= 1'b0;
      result       <= `RST_READING;
    end else begin
      acc          <= next_acc;
      count        <= next_count;
      result_valid <= next_result_valid;
      result       <= next_result;
    end
  end

  // A group completes only after sixteen samples
  group_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (result_valid && average_en && !clear) |-> $past(count) == SHIFT'(SAMPLES - 1))
    else $error("averaged result before sixteen samples");

endmodule // reading_averager

/* File: rtl/correct_and_compare.sv */
// Adds a signed correction to a reading with saturation and checks limits.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ps
`include "temp_params.svh"

module correct_and_compare (
  input  wire temp_pkg::reading_t     raw,
  input  wire logic [7:0]             correction,
  input  wire temp_pkg::limits_t      limits,
  output temp_pkg::reading_t          corrected,
  output temp_pkg::limit_flags_t      flags
);
  import temp_pkg::*;

  localparam int SUM_W = `READING_W + 2;

  logic signed [SUM_W-1:0] sum;
  logic signed [SUM_W-1:0] scaled;

  // Correction counts eighths of a degree; a reading counts 1/32, hence the shift
  always_comb begin
    scaled = SUM_W'(signed'({{(SUM_W-10){correction[7]}}, correction, 2'b00}));
    sum    = signed'({2'b00, raw}) + scaled;
    if (sum < 0) begin
      corrected = '0;
    end else if (sum > signed'({2'b00, `READING_MAX})) begin
      corrected = `READING_MAX;
    end else begin
      corrected = sum[`READING_W-1:0];
    end
    flags.high     = corrected[`READING_W-1:`FRACTION_W] >= limits.high;
    flags.low      = corrected[`READING_W-1:`FRACTION_W] <  limits.low;
    flags.overtemp = corrected[`READING_W-1:`FRACTION_W] >= limits.overtemp;
  end

endmodule // correct_and_compare

/* File: rtl/temp_result_format_and_control.sv */
// Digital back end of a two-channel temperature monitor: sequencing, averaging,
// correction, limit checks and the result/limit registers.
// Assumes a bus engine presents one-cycle read and write strobes with an address,
// and a converter that returns raw 13-bit samples for the channel it was started on.
//
// How it works
// - Each channel's reading is 13 bits: a whole byte and a fraction register.
// - Whole byte is unsigned degrees plus 64; zero means -64, all ones 191.
// - Fraction field holds five bits of 1/32 degree each.
// - Local fraction reads at 0x40, remote fraction at 0x42.
// - At eight conversions per second or slower, readings average sixteen samples.
// - At sixteen per second or faster each raw sample is stored directly.
// - Averaging-disable bit 1 of config one turns averaging off at slow rates.
// - Remote slot lasts 32 ms averaged, 6 ms unaveraged.
// - Round-robin bit 7 of config two alternates channels; zero keeps one.
// - In single-channel mode bit 4 picks local (0, default) or remote (1).
// - The channel's signed correction is added before the reading is stored.
// - Corrections are 8-bit signed eighths of a degree, reset zero.
// - Each channel has high, low and overtemp limits that raise flags.
// - Out of limit means at or above high, or strictly below low.
// - Reading a fraction freezes that channel's bytes until its whole byte is read.
// - Local slot lasts 11 ms; bit 0 of config one runs or stops monitoring.
`timescale 1ns/1ps
`include "temp_params.svh"

module temp_result_format_and_control #(
  parameter int TIMER_W          = 20,
  parameter int LOCAL_SLOT_CYC   = (`SLOT_LOCAL_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
  parameter int REMOTE_AVG_CYC   = (`SLOT_REMOTE_AVG_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
  parameter int REMOTE_RAW_CYC   = (`SLOT_REMOTE_RAW_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_write,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_read,
  output logic [7:0]                 reg_rdata,
  input  wire logic                  conv_rate_fast,
  output logic                       conv_start,
  output logic                       conv_remote,
  input  wire logic                  sample_valid,
  input  wire temp_pkg::reading_t    sample,
  output temp_pkg::limit_flags_t     local_flags,
  output temp_pkg::limit_flags_t     remote_flags
);
  import temp_pkg::*;

  // Registers
  logic [7:0]   config_one;
  logic [7:0]   config_two;
  limits_t      local_limits;
  limits_t      remote_limits;
  logic [7:0]   local_correction;
  logic [7:0]   remote_correction;
  reading_t     local_reading;
  reading_t     remote_reading;
  reading_t     local_shown;
  reading_t     remote_shown;
  logic [1:0]   frozen;
  logic [7:0]   next_config_one;
  logic [7:0]   next_config_two;
  limits_t      next_local_limits;
  limits_t      next_remote_limits;
  logic [7:0]   next_local_correction;
  logic [7:0]   next_remote_correction;
  reading_t     next_local_shown;
  reading_t     next_remote_shown;
  logic [1:0]   next_frozen;
  logic [7:0]   next_reg_rdata;

  // Sequencer
  seq_state_t          state;
  seq_state_t          next_state;
  logic [TIMER_W-1:0]  timer;
  logic [TIMER_W-1:0]  next_timer;
  logic                slot_remote;
  logic                next_slot_remote;
  logic                slot_avg;
  logic                next_slot_avg;
  logic                next_conv_start;

  // Result path
  logic                avg_valid;
  reading_t            avg_result;
  reading_t            corrected;
  limit_flags_t        cmp_flags;
  reading_t            next_local_reading;
  reading_t            next_remote_reading;
  limit_flags_t        next_local_flags;
  limit_flags_t        next_remote_flags;

  // Helpers for the fraction/whole register pair of a channel
  function automatic logic [7:0] whole_byte(input reading_t r);
    whole_byte = r[`READING_W-1:`FRACTION_W];
  endfunction

  function automatic logic [7:0] fraction_byte(input reading_t r);
    fraction_byte = {3'b000, r[`FRACTION_W-1:0]};
  endfunction

  // Register writes, freeze tracking and read data
  always_comb begin
    next_config_one        = config_one;
    next_config_two        = config_two;
    next_local_limits      = local_limits;
    next_remote_limits     = remote_limits;
    next_local_correction  = local_correction;
    next_remote_correction = remote_correction;
    next_frozen            = frozen;
    next_reg_rdata         = reg_rdata;
    if (reg_write) begin
      case (reg_addr)
        `ADDR_CONFIG_ONE:        next_config_one         = reg_wdata;
        `ADDR_CONFIG_TWO:        next_config_two         = reg_wdata;
        `ADDR_LOCAL_HIGH:        next_local_limits.high  = reg_wdata;
        `ADDR_LOCAL_LOW:         next_local_limits.low   = reg_wdata;
        `ADDR_LOCAL_OVERTEMP:    next_local_limits.overtemp = reg_wdata;
        `ADDR_REMOTE_HIGH:       next_remote_limits.high = reg_wdata;
        `ADDR_REMOTE_LOW:        next_remote_limits.low  = reg_wdata;
        `ADDR_REMOTE_OVERTEMP:   next_remote_limits.overtemp = reg_wdata;
        `ADDR_LOCAL_CORRECTION:  next_local_correction   = reg_wdata;
        `ADDR_REMOTE_CORRECTION: next_remote_correction  = reg_wdata;
        default: ; // Read-only and unmapped offsets ignore writes
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        `ADDR_CONFIG_ONE:        next_reg_rdata = config_one;
        `ADDR_CONFIG_TWO:        next_reg_rdata = config_two;
        `ADDR_LOCAL_HIGH:        next_reg_rdata = local_limits.high;
        `ADDR_LOCAL_LOW:         next_reg_rdata = local_limits.low;
        `ADDR_LOCAL_OVERTEMP:    next_reg_rdata = local_limits.overtemp;
        `ADDR_REMOTE_HIGH:       next_reg_rdata = remote_limits.high;
        `ADDR_REMOTE_LOW:        next_reg_rdata = remote_limits.low;
        `ADDR_REMOTE_OVERTEMP:   next_reg_rdata = remote_limits.overtemp;
        `ADDR_LOCAL_CORRECTION:  next_reg_rdata = local_correction;
        `ADDR_REMOTE_CORRECTION: next_reg_rdata = remote_correction;
        `ADDR_LOCAL_FRACTION: begin
          next_reg_rdata = fraction_byte(local_shown);
          next_frozen[0] = 1'b1;
        end
        `ADDR_LOCAL_WHOLE: begin
          next_reg_rdata = whole_byte(local_shown);
          next_frozen[0] = 1'b0;
        end
        `ADDR_REMOTE_FRACTION: begin
          next_reg_rdata = fraction_byte(remote_shown);
          next_frozen[1] = 1'b1;
        end
        `ADDR_REMOTE_WHOLE: begin
          next_reg_rdata = whole_byte(remote_shown);
          next_frozen[1] = 1'b0;
        end
        default:                 next_reg_rdata = 8'h00;
      endcase
    end
    // The host sees a frozen copy; the live reading keeps updating underneath.
    // Holding from the fraction read itself keeps both bytes from one reading.
    next_local_shown  = next_frozen[0] ? local_shown  : local_reading;
    next_remote_shown = next_frozen[1] ? remote_shown : remote_reading;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      config_one        <= `RST_CONFIG_ONE;
      config_two        <= `RST_CONFIG_TWO;
      local_limits      <= {`RST_HIGH_LIMIT, `RST_LOW_LIMIT, `RST_OVERTEMP_LIMIT};
      remote_limits     <= {`RST_HIGH_LIMIT, `RST_LOW_LIMIT, `RST_OVERTEMP_LIMIT};
      local_correction  <= `RST_CORRECTION;
      remote_correction <= `RST_CORRECTION;
      local_shown       <= `RST_READING;
      remote_shown      <= `RST_READING;
      frozen            <= 2'b00;
      reg_rdata         <= 8'h00;
    end else begin
      config_one        <= next_config_one;
      config_two        <= next_config_two;
      local_limits      <= next_local_limits;
      remote_limits     <= next_remote_limits;
      local_correction  <= next_local_correction;
      remote_correction <= next_remote_correction;
      local_shown       <= next_local_shown;
      remote_shown      <= next_remote_shown;
      frozen            <= next_frozen;
      reg_rdata         <= next_reg_rdata;
    end
  end

  // Slot sequencer: settings are sampled only at a slot boundary
  always_comb begin
    next_state       = state;
    next_timer       = timer;
    next_slot_remote = slot_remote;
    next_slot_avg    = slot_avg;
    next_conv_start  = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (config_one[`CFG1_MONITOR_RUN_BIT]) begin
          next_state = SEQ_START;
        end
      end
      SEQ_START: begin
        next_slot_avg   = !conv_rate_fast && !config_one[`CFG1_AVG_DISABLE_BIT];
        next_conv_start = 1'b1;
        if (!config_two[`CFG2_ROUND_ROBIN_BIT]) begin
          next_slot_remote = config_two[`CFG2_CHANNEL_SEL_BIT];
        end
        if (next_slot_remote) begin
          next_timer = next_slot_avg ? TIMER_W'(REMOTE_AVG_CYC - 1)
                                     : TIMER_W'(REMOTE_RAW_CYC - 1);
        end else begin
          next_timer = TIMER_W'(LOCAL_SLOT_CYC - 1);
        end
        next_state = SEQ_CONVERT;
      end
      SEQ_CONVERT: begin
        if (timer != '0) begin
          next_timer = timer - 1'b1;
        end else begin
          if (config_two[`CFG2_ROUND_ROBIN_BIT]) begin
            next_slot_remote = !slot_remote;
          end
          // Stopping takes effect at the slot end so a conversion finishes
          next_state = config_one[`CFG1_MONITOR_RUN_BIT] ? SEQ_START : SEQ_IDLE;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state       <= SEQ_IDLE;
      timer       <= '0;
      slot_remote <= 1'b1; // First round-robin slot is remote
      slot_avg    <= 1'b0;
      conv_start  <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      slot_remote <= next_slot_remote;
      slot_avg    <= next_slot_avg;
      conv_start  <= next_conv_start;
    end
  end

  assign conv_remote = slot_remote;

  // Samples count only inside a slot; the group restarts at each slot start.
  // A sample in the last slot cycle is dropped: its result would meet the next channel.
  reading_averager u_averager (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .clear        (state == SEQ_START),
    .average_en   (slot_avg),
    .sample_valid (sample_valid && state == SEQ_CONVERT && timer != '0),
    .sample       (sample),
    .result_valid (avg_valid),
    .result       (avg_result)
  );

  correct_and_compare u_correct (
    .raw        (avg_result),
    .correction (slot_remote ? remote_correction : local_correction),
    .limits     (slot_remote ? remote_limits : local_limits),
    .corrected  (corrected),
    .flags      (cmp_flags)
  );

  // Store the corrected reading and its limit flags for the slot's channel
  always_comb begin
    next_local_reading  = local_reading;
    next_remote_reading = remote_reading;
    next_local_flags    = local_flags;
    next_remote_flags   = remote_flags;
    if (avg_valid && slot_remote) begin
      next_remote_reading = corrected;
      next_remote_flags   = cmp_flags;
    end else if (avg_valid) begin
      next_local_reading = corrected;
      next_local_flags   = cmp_flags;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      local_reading  <= `RST_READING;
      remote_reading <= `RST_READING;
      local_flags    <= '0;
      remote_flags   <= '0;
    end else begin
      local_reading  <= next_local_reading;
      remote_reading <= next_remote_reading;
      local_flags    <= next_local_flags;
      remote_flags   <= next_remote_flags;
    end
  end

  // Checks
  avg_select_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == SEQ_START |=> slot_avg == !($past(conv_rate_fast)
                                         || $past(config_one[`CFG1_AVG_DISABLE_BIT])))
    else $error("averaging choice wrong at slot start");

  slot_settled_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == SEQ_CONVERT && timer != '0) |=> ($stable(slot_remote) && $stable(slot_avg)))
    else $error("slot settings changed mid conversion");

  remote_slot_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == SEQ_START ##1 (slot_remote && slot_avg))
      |-> timer == TIMER_W'(REMOTE_AVG_CYC - 1))
    else $error("remote averaged slot length wrong");

  local_slot_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == SEQ_START ##1 !slot_remote) |-> timer == TIMER_W'(LOCAL_SLOT_CYC - 1))
    else $error("local slot length wrong");

  alternate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == SEQ_CONVERT && timer == '0 && config_two[`CFG2_ROUND_ROBIN_BIT])
      |=> slot_remote != $past(slot_remote))
    else $error("round robin did not alternate");

  stopped_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == SEQ_IDLE && !config_one[`CFG1_MONITOR_RUN_BIT]) |=> state == SEQ_IDLE ##1 !conv_start)
    else $error("conversion started while stopped");

  freeze_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (frozen[0] && !(reg_read && reg_addr == `ADDR_LOCAL_WHOLE)) |=> $stable(local_shown))
    else $error("frozen local reading changed");

  freeze_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_read && reg_addr == `ADDR_REMOTE_FRACTION) |=> frozen[1]
      && reg_rdata == {3'b000, $past(remote_shown[`FRACTION_W-1:0])})
    else $error("remote fraction read did not freeze");

  high_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (avg_valid && !slot_remote) |=> local_flags.high
      == (local_reading[`READING_W-1:`FRACTION_W] >= $past(local_limits.high)))
    else $error("local high flag mismatch");

  saturate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (avg_valid && !slot_remote && !local_correction[7])
      |=> local_reading >= $past(avg_result))
    else $error("positive correction wrapped");

  cover_both_cov: cover property (@(posedge clk_sys) disable iff (sys_rst)
    avg_valid && slot_remote && slot_avg);
  cover_freeze_cov: cover property (@(posedge clk_sys) disable iff (sys_rst)
    frozen[0] && avg_valid && !slot_remote);
  cover_stop_cov: cover property (@(posedge clk_sys) disable iff (sys_rst)
    state == SEQ_CONVERT ##1 state == SEQ_IDLE);

endmodule // temp_result_format_and_control

/* File: verif/sample_source.sv */
// Converter stand-in: answers each slot start with a ramp of sixteen samples.
// Assumes slot starts come as one-cycle pulses; drives on the falling edge.
`timescale 1ns/1ps

module sample_source (
  input  wire logic               clk_sys,
  input  wire logic               conv_start,
  input  wire logic               conv_remote,
  input  wire temp_pkg::reading_t local_base,
  input  wire temp_pkg::reading_t remote_base,
  output logic                    sample_valid = 1'b0,
  output temp_pkg::reading_t      sample = 13'h0000
);
  int                 left = 0;
  temp_pkg::reading_t base;

  // One quiet cycle after the start pulse, then the ramp; idle data toggles
  // so a stale code is never mistaken for a fresh one
  always @(negedge clk_sys) begin
    if (conv_start) begin
      left = 17;
      base = conv_remote ? remote_base : local_base;
    end else if (left > 0) begin
      left--;
    end
    sample_valid <= (left > 0 && left < 17);
    sample <= (left > 0 && left < 17) ? base + 13'(16 - left) : ~sample;
  end
endmodule // sample_source

/* File: verif/test_temp_result_format_and_control.sv */
// Scenario bench for the temperature result back end.
// Assumes the converter stand-in and short slots of 40, 100 and 30 cycles.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module test_temp_result_format_and_control;
  import temp_pkg::*;
  logic         clk_sys = 0, sys_rst = 1, reg_write = 0, reg_read = 0, fast = 1;
  logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
  logic         conv_start, conv_remote, sample_valid;
  reading_t     sample, lbase = 13'h0a80, rbase = 13'h1160;
  limit_flags_t local_flags, remote_flags;
  int           error_cnt = 0, compares = 0;

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  temp_result_format_and_control #(.LOCAL_SLOT_CYC(40), .REMOTE_AVG_CYC(100),
    .REMOTE_RAW_CYC(30)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .conv_rate_fast(fast),
    .conv_start(conv_start), .conv_remote(conv_remote), .sample_valid(sample_valid),
    .sample(sample), .local_flags(local_flags), .remote_flags(remote_flags));

  sample_source u_src (.clk_sys(clk_sys), .conv_start(conv_start),
    .conv_remote(conv_remote), .local_base(lbase), .remote_base(rbase),
    .sample_valid(sample_valid), .sample(sample));

  // Register accesses: one-cycle strobes raised and dropped on falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys) {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys) reg_write = 0;
  endtask
  task automatic rdx(input logic [7:0] a);
    @(negedge clk_sys) {reg_read, reg_addr} = {1'b1, a};
    @(negedge clk_sys) reg_read = 0;
    @(negedge clk_sys) rd = reg_rdata;
  endtask
  task automatic slots(input int n);
    repeat (n) @(posedge conv_start);
  endtask
  // Mode changes only land at a slot boundary, so give them a few slots
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2);
    wr(8'h01, c1);
    wr(8'h02, c2);
    slots(4);
  endtask
  task automatic chk_rd(input logic r, input reading_t e, input limit_flags_t f);
    rdx(r ? 8'h42 : 8'h40);
    `CHK(rd, {3'h0, e[4:0]})
    rdx(r ? 8'h43 : 8'h41);
    `CHK(rd, e[12:5])
    `CHK(r ? remote_flags : local_flags, f)
  endtask

  task automatic t_reset;
    // First slot is remote: its bytes are read before any result lands, and the
    // second whole read proves the freeze while live results arrive
    logic [7:0] a [17] = '{8'h43, 8'h42, 8'h43, 8'h41, 8'h40, 8'h41, 8'h01, 8'h02, 8'h0b,
                           8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h16, 8'h17, 8'h30};
    logic [7:0] e [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h80, 8'h8b,
                           8'h54, 8'h95, 8'h8b, 8'h54, 8'h95, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 17; i++) begin
      rdx(a[i]);
      `CHK(rd, e[i])
    end
    $display("t_reset end");
  endtask

  task automatic t_round_robin;
    logic was;
    int   n;
    @(posedge conv_start);
    @(negedge clk_sys);
    repeat (4) begin
      was = conv_remote;
      n = 0;
      do begin
        @(negedge clk_sys) n++;
      end while (!conv_start);
      `CHK(n, was ? 31 : 41)
      `CHK(conv_remote, !was)
    end
    $display("t_round_robin end");
  endtask

  task automatic t_fast_local;
    wr(8'h16, 8'h08);
    cfg(8'h01, 8'h00);
    chk_rd(0, 13'h0aaf, 3'b000);
    $display("t_fast_local end");
  endtask

  task automatic t_freeze;
    rdx(8'h40);
    lbase = 13'h0c80;
    slots(3);
    rdx(8'h41);
    `CHK(rd, 8'h55)
    slots(2);
    chk_rd(0, 13'h0caf, 3'b000);
    $display("t_freeze end");
  endtask

  task automatic t_avg_remote;
    fast = 0;
    wr(8'h17, 8'hf8);
    wr(8'h0e, 8'h8a);
    cfg(8'h01, 8'h90);
    chk_rd(1, 13'h1147, 3'b100);
    cfg(8'h03, 8'h10);
    chk_rd(1, 13'h114f, 3'b100);
    `CHK(conv_remote, 1'b1)
    $display("t_avg_remote end");
  endtask

  task automatic t_saturate;
    wr(8'h16, 8'h80);
    lbase = 13'h0100;
    cfg(8'h03, 8'h00);
    chk_rd(0, 13'h0000, 3'b010);
    wr(8'h16, 8'h7f);
    lbase = 13'h1ff0;
    slots(4);
    chk_rd(0, 13'h1fff, 3'b101);
    $display("t_saturate end");
  endtask

  // Stop lets the running slot finish, then no slot starts until restarted
  task automatic t_stop;
    int n = 0;
    wr(8'h01, 8'h02);
    repeat (200) @(negedge clk_sys) n += conv_start;
    `CHK(n, 0)
    wr(8'h01, 8'h03);
    n = 0;
    do begin
      @(negedge clk_sys) n++;
    end while (!conv_start && n < 50);
    `CHK(n, 2)
    $display("t_stop end");
  endtask

  task automatic final_report;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: the scenarios need about 1600 cycles
  initial begin
    repeat (6000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge clk_sys);
    sys_rst = 0;
    t_reset();
    t_round_robin();
    t_fast_local();
    t_freeze();
    t_avg_remote();
    t_saturate();
    t_stop();
    final_report();
  end
endmodule // test_temp_result_format_and_control
